// ===== design/wwd_params.svh
`ifndef WWD_PARAMS_SVH
`define WWD_PARAMS_SVH
// Register byte offsets
`define WWD_OFS_CTRL 32'h00000000
`define WWD_OFS_WINDOW 32'h00000004
`define WWD_OFS_CLKCTL 32'h00000008
`define WWD_OFS_STATUS 32'h0000000C
// Control register fields
`define WWD_CTRL_ACT_BIT 7
`define WWD_CNT_TOP_BIT 6
// Reset values, and counter value whose decrement requests reset
`define WWD_CTRL_RESET 8'h7F
`define WWD_WINDOW_RESET 7'h7F
`define WWD_CNT_ROLL_FROM 7'h40
// Timing counts
`define WWD_DECR_PERIOD 16384
`define WWD_DELAY_SHORT 256
`define WWD_DELAY_LONG 4096
// Timebase prescaler periods
`define WWD_TB0_PERIOD 16000
`define WWD_TB1_PERIOD 32000
`define WWD_TB2_PERIOD 80000
`define WWD_TB3_PERIOD 200000
// Timeout formula constants per timebase
`define WWD_TB0_MSB 8'd4
`define WWD_TB0_LSB 8'd59
`define WWD_TB1_MSB 8'd8
`define WWD_TB1_LSB 8'd53
`define WWD_TB2_MSB 8'd20
`define WWD_TB2_LSB 8'd35
`define WWD_TB3_MSB 8'd49
`define WWD_TB3_LSB 8'd54
`define WWD_MIN0_BASE 128
`define WWD_ELSE_BASE 192
`define WWD_STEP_MULT 64
`endif

// ===== design/wwd_pkg.sv
package wwd_pkg;
	typedef enum logic [2:0] {
		WWD_RUN,
		WWD_HALT_STEP,
		WWD_HALT_STOP,
		WWD_ACTIVE_HALT,
		WWD_RESTART_WAIT
	} wwd_state_e;
	typedef struct packed {
		logic halt_req;
		logic wake_irq;
		logic wake_rtc;
		logic wake_reset;
	} wwd_power_s;
	typedef struct packed {
		logic [7:0] msb;
		logic [7:0] lsb;
	} wwd_tbconst_s;
endpackage

// ===== design/wwd_divider.sv
`timescale 1ns/100ps
`default_nettype none
// Divider: one-cycle tick every period cycles while run is high, restarted by clear
module wwd_divider #(
	parameter int PERIOD = 16384,
	parameter int W = 18
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic run,
	input wire logic clear,
	input wire logic [W-1:0] period,
	// Tick out
	output logic tick
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic next_tick;

	// Count up to the period, restart on clear
	always_comb
	begin
		next_count = count;
		next_tick = 1'b0;
		if (clear)
			next_count = '0;
		else if (run)
		begin
			if (count >= period - W'(1))
			begin
				next_count = '0;
				next_tick = 1'b1;
			end
			else
				next_count = count + W'(1);
		end
	end

	// Register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count <= '0;
			tick <= 1'b0;
		end
		else
		begin
			count <= next_count;
			tick <= next_tick;
		end
	end
endmodule
`default_nettype wire

// ===== design/wwd_top.sv
// Summary of operation
// - Timeout count is counter low six bits
// - Report min/max timeout from formula constants
// - Timebase selects formula MSB/LSB constant pair
// - Slow and wait modes keep counting
// - Plain halt: one decrement, then stop
// - Interrupt wake from halt: delayed restart
// - Reset wake clears activation unless hardware
// - Reset-on-halt option turns halt into reset when watchdog active and timebase irq disabled
// - Timebase irq enabled: active-halt, counter stops
// - Active-halt interrupt wake resumes immediately
// - Active-halt reset wake: delayed restart
// - Hardware option keeps watchdog always active
// - Decrement per 16384 cycles, reset 40h to 3Fh
// - Control write while counter is above window value causes reset
// - Activation set by software, cleared by reset
// - Timebase select chooses one of four formula constant pairs
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "wwd_params.svh"
module wwd_top
	import wwd_pkg::*;
#(
	parameter int DECR_PERIOD = `WWD_DECR_PERIOD,
	parameter int DELAY_LONG = `WWD_DELAY_LONG
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Static options
	input wire logic hw_watchdog_option,
	input wire logic reset_on_halt_option,
	input wire logic long_restart_delay,
	// Power events
	input wire logic halt_req,
	input wire logic wake_irq,
	input wire logic wake_rtc,
	input wire logic wake_reset,
	// AXI4-Lite write
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Reset request and state
	output logic wd_reset_req,
	output logic halted
);
	localparam int DW = 18;
	wwd_power_s pwr;
	assign pwr = '{halt_req: halt_req, wake_irq: wake_irq,
		wake_rtc: wake_rtc, wake_reset: wake_reset};

	// Registers
	logic activation_bit, next_activation_bit;
	logic [6:0] counter, next_counter;
	logic [6:0] wd_window_reg, next_wd_window_reg;
	logic [1:0] timebase_select, next_timebase_select;
	logic timebase_irq_enable, next_timebase_irq_enable;
	logic next_wd_reset_req;
	wwd_state_e state, next_state;
	logic [12:0] delay_cnt, next_delay_cnt;
	// Bus state
	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [31:0] aw_addr, next_aw_addr, w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic next_halted;
	// Timeout figures
	logic [31:0] tmin, tmax, next_tmin, next_tmax;
	wwd_tbconst_s tbc;
	logic dec_tick, div_run, div_clear;
	logic wr_fire, wd_active;
	logic [5:0] timeout_count_value;
	logic [7:0] q;

	// Decrement prescaler
	wwd_divider #(.PERIOD(DECR_PERIOD), .W(DW)) u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(div_run),
		.clear(div_clear),
		.period(DW'(DECR_PERIOD)),
		.tick(dec_tick)
	);

	assign wd_active = activation_bit | hw_watchdog_option;
	assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
	assign timeout_count_value = counter[5:0];
	// Prescaler runs in run and slow/wait, and for one step into halt
	assign div_run = (state == WWD_RUN) || (state == WWD_HALT_STEP);
	assign div_clear = (state == WWD_RESTART_WAIT);

	// Formula constants per timebase
	always_comb
	begin
		case (timebase_select)
			2'b00: tbc = '{msb: `WWD_TB0_MSB, lsb: `WWD_TB0_LSB};
			2'b01: tbc = '{msb: `WWD_TB1_MSB, lsb: `WWD_TB1_LSB};
			2'b10: tbc = '{msb: `WWD_TB2_MSB, lsb: `WWD_TB2_LSB};
			default: tbc = '{msb: `WWD_TB3_MSB, lsb: `WWD_TB3_LSB};
		endcase
	end

	// Timeout bounds in oscillator periods
	always_comb
	begin
		logic [31:0] cnt32, base_min;
		cnt32 = 32'(timeout_count_value);
		base_min = (32'(tbc.lsb) + 32'(`WWD_MIN0_BASE)) * 32'(`WWD_STEP_MULT);
		q = 8'((cnt32 * 32'd4) / 32'(tbc.msb));
		next_tmin = base_min + 32'(`WWD_DECR_PERIOD) * cnt32;
		next_tmax = 32'(`WWD_DECR_PERIOD) + 32'(`WWD_DECR_PERIOD) * cnt32;
		if (cnt32 >= 32'(tbc.msb) / 32'd4)
			next_tmin = base_min + 32'(`WWD_DECR_PERIOD) * (cnt32 - 32'(q))
				+ (32'(`WWD_ELSE_BASE) + 32'(tbc.lsb)) * 32'(`WWD_STEP_MULT) * 32'(q);
		if (cnt32 > 32'(tbc.msb) / 32'd4)
			next_tmax = 32'(`WWD_DECR_PERIOD) + 32'(`WWD_DECR_PERIOD) * (cnt32 - 32'(q))
				+ (32'(`WWD_ELSE_BASE) + 32'(tbc.lsb)) * 32'(`WWD_STEP_MULT) * 32'(q);
	end

	// Watchdog core and power-mode sequencing
	always_comb
	begin
		next_activation_bit = activation_bit;
		next_counter = counter;
		next_wd_window_reg = wd_window_reg;
		next_timebase_select = timebase_select;
		next_timebase_irq_enable = timebase_irq_enable;
		next_wd_reset_req = 1'b0;
		next_state = state;
		next_delay_cnt = delay_cnt;
		next_halted = (state != WWD_RUN) && (state != WWD_RESTART_WAIT);
		// Free-running decrement
		if (dec_tick)
		begin
			next_counter = counter - 7'h01;
			if (counter == `WWD_CNT_ROLL_FROM && wd_active)
				next_wd_reset_req = 1'b1;
		end
		// Register writes
		if (wr_fire && w_strb[0])
		begin
			case (aw_addr)
				`WWD_OFS_CTRL:
				begin
					if (w_data[`WWD_CTRL_ACT_BIT])
						next_activation_bit = 1'b1;
					next_counter = w_data[6:0];
					if (wd_active && counter > wd_window_reg)
						next_wd_reset_req = 1'b1;
					if (w_data[`WWD_CTRL_ACT_BIT] && !w_data[`WWD_CNT_TOP_BIT])
						next_wd_reset_req = 1'b1;
				end
				`WWD_OFS_WINDOW: next_wd_window_reg = w_data[6:0];
				`WWD_OFS_CLKCTL:
				begin
					next_timebase_select = w_data[3:2];
					next_timebase_irq_enable = w_data[1];
				end
				default: ;
			endcase
		end
		// Power sequencing
		case (state)
			WWD_RUN:
				if (pwr.halt_req)
				begin
					if (timebase_irq_enable)
						next_state = WWD_ACTIVE_HALT;
					else if (reset_on_halt_option && wd_active)
						next_wd_reset_req = 1'b1;
					else
						next_state = WWD_HALT_STEP;
				end
			WWD_HALT_STEP:
				if (dec_tick)
					next_state = WWD_HALT_STOP;
			WWD_HALT_STOP, WWD_ACTIVE_HALT:
			begin
				next_wd_reset_req = 1'b0;
				if (pwr.wake_reset)
				begin
					if (!hw_watchdog_option)
						next_activation_bit = 1'b0;
					next_state = WWD_RESTART_WAIT;
					next_delay_cnt = '0;
				end
				else if (state == WWD_ACTIVE_HALT && (pwr.wake_irq || pwr.wake_rtc))
					next_state = WWD_RUN;
				else if (state == WWD_HALT_STOP && pwr.wake_irq)
				begin
					next_state = WWD_RESTART_WAIT;
					next_delay_cnt = '0;
				end
			end
			WWD_RESTART_WAIT:
			begin
				next_delay_cnt = delay_cnt + 13'h0001;
				if (32'(delay_cnt) + 32'd1 >= (long_restart_delay ?
					32'(DELAY_LONG) : 32'(`WWD_DELAY_SHORT)))
					next_state = WWD_RUN;
			end
			default: next_state = WWD_RUN;
		endcase
	end

	// Bus write/read channel next values
	always_comb
	begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_awready = 1'b0;
		next_wready = 1'b0;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_arready = 1'b0;
		next_rvalid = s_axi_rvalid;
		next_rresp = s_axi_rresp;
		next_rdata = s_axi_rdata;
		// Capture address and data in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (!aw_held && !s_axi_awready && s_axi_awvalid)
			next_awready = 1'b1;
		if (!w_held && !s_axi_wready && s_axi_wvalid)
			next_wready = 1'b1;
		// Write response
		if (wr_fire)
		begin
			next_bvalid = 1'b1;
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bresp = (aw_addr == `WWD_OFS_CTRL || aw_addr == `WWD_OFS_WINDOW ||
				aw_addr == `WWD_OFS_CLKCTL || aw_addr == `WWD_OFS_STATUS) ? 2'b00 : 2'b10;
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		// Read
		if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid)
			next_arready = 1'b1;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rresp = 2'b00;
			case (s_axi_araddr)
				`WWD_OFS_CTRL: next_rdata = {24'h000000, activation_bit, counter};
				`WWD_OFS_WINDOW: next_rdata = {25'h0000000, wd_window_reg};
				`WWD_OFS_CLKCTL: next_rdata = {28'h0000000, timebase_select,
					timebase_irq_enable, 1'b0};
				`WWD_OFS_STATUS: next_rdata = {29'h0000000, 3'(state)};
				32'h00000010: next_rdata = tmin;
				32'h00000014: next_rdata = tmax;
				default:
				begin
					next_rdata = 32'h00000000;
					next_rresp = 2'b10;
				end
			endcase
		end
		if (s_axi_rvalid && s_axi_rready)
			next_rvalid = 1'b0;
	end

	// Register all state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			activation_bit <= 1'(`WWD_CTRL_RESET >> `WWD_CTRL_ACT_BIT);
			counter <= 7'(`WWD_CTRL_RESET);
			wd_window_reg <= `WWD_WINDOW_RESET;
			timebase_select <= 2'h0;
			timebase_irq_enable <= 1'b0;
			wd_reset_req <= 1'b0;
			state <= WWD_RUN;
			delay_cnt <= 13'h0000;
			halted <= 1'b0;
			tmin <= 32'h00000000;
			tmax <= 32'h00000000;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 32'h00000000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h00000000;
		end
		else
		begin
			activation_bit <= next_activation_bit;
			counter <= next_counter;
			wd_window_reg <= next_wd_window_reg;
			timebase_select <= next_timebase_select;
			timebase_irq_enable <= next_timebase_irq_enable;
			wd_reset_req <= next_wd_reset_req;
			state <= next_state;
			delay_cnt <= next_delay_cnt;
			halted <= next_halted;
			tmin <= next_tmin;
			tmax <= next_tmax;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
		end
	end
endmodule
`default_nettype wire

// ===== verification/wwd_checker.sv
`timescale 1ns/100ps
`default_nettype none
module wwd_checker #(
	parameter int DECR_PERIOD = 16,
	parameter int DELAY_LONG = 64
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Stimulus seen
	input wire logic reset_on_halt_option,
	input wire logic halt_req,
	input wire logic wake_irq,
	input wire logic wake_rtc,
	input wire logic wake_reset,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_rready,
	// Responses watched
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic wd_reset_req,
	input wire logic halted
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Handshake steps
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_pulse_once: assert property (wd_reset_req |=> !wd_reset_req)
		else $error("reset request held too long");
	chk_write_resp: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	chk_read_resp: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read response late");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read response dropped");
	chk_halt_enter: assert property (halt_req && !reset_on_halt_option && !halted |-> ##[1:2] halted)
		else $error("halt not entered");
	chk_halt_hold: assert property (halted && !(wake_irq || wake_rtc || wake_reset)
		&& !$past(wake_irq || wake_rtc || wake_reset) |=> halted)
		else $error("halt left without wake");
	chk_halt_quiet: assert property (halted && $past(halted) |-> !wd_reset_req)
		else $error("reset request while halted");
endmodule
bind wwd_top wwd_checker #(.DECR_PERIOD(DECR_PERIOD), .DELAY_LONG(DELAY_LONG)) u_chk (
	.aclk, .aresetn, .reset_on_halt_option, .halt_req, .wake_irq, .wake_rtc, .wake_reset,
	.s_axi_awvalid, .s_axi_wvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_rready,
	.s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid,
	.wd_reset_req, .halted
);
`default_nettype wire

// ===== verification/wwd_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module wwd_tb_top;
	localparam int DP = 16;
	localparam int DL = 64;
	logic aclk, aresetn, hw_watchdog_option, reset_on_halt_option, halt_req, wake_irq, wake_rtc;
	logic wake_reset, long_restart_delay;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, wd_reset_req, halted;
	logic [1:0] s_axi_rresp, s_axi_bresp;
	logic [33:0] q[$];
	int mismatches, total_checks, rst_seen;
	int msbs[4] = '{4, 8, 20, 49};
	int lsbs[4] = '{59, 53, 35, 54};
	wwd_top #(.DECR_PERIOD(DP), .DELAY_LONG(DL)) uut (
		.aclk, .aresetn, .hw_watchdog_option, .reset_on_halt_option, .long_restart_delay,
		.halt_req, .wake_irq, .wake_rtc, .wake_reset,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .wd_reset_req, .halted
	);
	// Clock
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task do_reset;
		aresetn <= 1'b0;
		cyc(20);
		aresetn <= 1'b1;
		cyc(1);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic pa;
		logic pw;
		@(posedge aclk);
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa || pw)
		begin
			@(posedge aclk);
			if (pa && s_axi_awready === 1'b1)
			begin
				s_axi_awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (pw && s_axi_wready === 1'b1)
			begin
				s_axi_wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		check(34'(s_axi_bresp), 34'h0);
		s_axi_bready <= 1'b0;
	endtask
	// Read notes its expectation for the monitor
	task automatic rd(input logic [31:0] a, input logic [33:0] e);
		@(posedge aclk);
		q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask
	task pulse(input int w);
		@(posedge aclk);
		halt_req <= (w == 0);
		wake_irq <= (w == 1);
		wake_rtc <= (w == 2);
		wake_reset <= (w == 3);
		@(posedge aclk);
		{halt_req, wake_irq, wake_rtc, wake_reset} <= 4'h0;
	endtask
	function automatic logic [31:0] tmo(input int c, input int m, input int l, input bit mx);
		int k;
		int b;
		k = 4 * c / m;
		b = mx ? 16384 : (l + 128) * 64;
		if (mx ? c <= m / 4 : c < m / 4)
			return 32'(b + 16384 * c);
		return 32'(b + 16384 * (c - k) + (192 + l) * 64 * k);
	endfunction
	// Read monitor and reset request counter
	always @(posedge aclk)
	begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
			check({s_axi_rresp, s_axi_rdata}, q.pop_front());
		if (wd_reset_req === 1'b1)
			rst_seen++;
	end
	// Tests
	initial
	begin
		int cnt;
		int base;
		{hw_watchdog_option, reset_on_halt_option, halt_req, wake_irq, wake_rtc, wake_reset} <= 6'h0;
		long_restart_delay <= 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} <= 96'h0;
		void'($urandom(32'h04EF));
		do_reset();
		rd(32'h0, 34'h7F);
		rd(32'h4, 34'h7F);
		rd(32'h8, 34'h0);
		rd(32'h20, 34'h200000000);
		$display("done reset values");
		base = rst_seen;
		wr(32'h0, 32'hC1);
		cyc(2 * DP + 4);
		check(34'(rst_seen), 34'(base + 1));
		do_reset();
		rd(32'h0, 34'h7F);
		$display("done roll");
		wr(32'h0, 32'hFF);
		cyc(4);
		check(34'(rst_seen), 34'(base + 1));
		wr(32'h4, 32'h50);
		wr(32'h0, 32'hFF);
		cyc(4);
		check(34'(rst_seen), 34'(base + 2));
		$display("done window");
		{hw_watchdog_option, reset_on_halt_option} <= 2'h3;
		do_reset();
		base = rst_seen;
		wr(32'h8, 32'h2);
		pulse(0);
		cyc(2);
		check(34'(halted), 34'h1);
		for (int tb = 0; tb < 4; tb++)
		begin
			cnt = $urandom % 64;
			wr(32'h8, 32'(tb * 4 + 2));
			wr(32'h0, 32'(cnt + 64));
			rd(32'h0, 34'(cnt + 64));
			rd(32'h10, {2'b00, tmo(cnt, msbs[tb], lsbs[tb], 1'b0)});
			rd(32'h14, {2'b00, tmo(cnt, msbs[tb], lsbs[tb], 1'b1)});
		end
		check(34'(rst_seen), 34'(base));
		pulse(2);
		cyc(2);
		check(34'(halted), 34'h0);
		do_reset();
		base = rst_seen;
		pulse(0);
		cyc(4);
		check(34'(rst_seen), 34'(base + 1));
		check(34'(halted), 34'h0);
		$display("done halt options");
		reset_on_halt_option <= 1'b0;
		do_reset();
		base = rst_seen;
		wr(32'h0, 32'h42);
		pulse(0);
		cyc(4 * DP);
		check(34'(rst_seen), 34'(base));
		pulse(1);
		cyc(DL - 2);
		check(34'(rst_seen), 34'(base));
		cyc(2 * DP + 6);
		check(34'(rst_seen), 34'(base + 1));
		$display("done plain halt");
		// Reset wake from halt: activation dropped, short restart delay
		{hw_watchdog_option, long_restart_delay} <= 2'h0;
		do_reset();
		base = rst_seen;
		wr(32'h0, 32'hC2);
		pulse(0);
		cyc(2 * DP);
		rd(32'h0, 34'hC1);
		pulse(3);
		rd(32'h0, 34'h41);
		cyc(240);
		rd(32'h0, 34'h41);
		cyc(30);
		rd(32'h0, 34'h40);
		cyc(2 * DP);
		check(34'(rst_seen), 34'(base));
		$display("done reset wake");
		conclude();
	end
	// Hang guard
	initial
	begin
		cyc(3000);
		mismatches++;
		conclude();
	end
endmodule
`default_nettype wire
